// *** src/irr_defs.svh ***
// Constants for the slave reset and bus-recovery block
`ifndef IRR_DEFS_SVH
`define IRR_DEFS_SVH

`define IRR_DEV_ADDR 7'h22
`define IRR_BITS_PER_BYTE 4'h8
`define IRR_CNT_ZERO 4'h0
`define IRR_CNT_ONE 4'h1
`define IRR_REG_DIR 1'h0
`define IRR_REG_OUT 1'h1
`define IRR_DIR_RST 8'hFF
`define IRR_OUT_RST 8'hFF
`define IRR_BYTE_ZERO 8'h00

`endif

// *** src/irr_pkg.sv ***
// Types shared by the slave reset and bus-recovery block
`default_nettype none
package irr_pkg;
    typedef enum logic [2:0] {
        IRR_IDLE  = 3'b000,
        IRR_ADDR  = 3'b001,
        IRR_AACK  = 3'b010,
        IRR_WDATA = 3'b011,
        IRR_WACK  = 3'b100,
        IRR_RDATA = 3'b101,
        IRR_RACK  = 3'b110
    } irr_state_t;
endpackage : irr_pkg
`default_nettype wire

// *** src/irr_pin_filt.sv ***
// Two-flop synchroniser plus two-sample agreement filter for bus pins
`default_nettype none
module irr_pin_filt
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Raw pins and filtered levels
    input wire logic [1:0] pin_i,
    output logic [1:0] filt_o
);
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : gen_bit
            logic meta_r;
            logic sync_r;
            logic hist_r;
            logic filt_r;
            wire agree = (sync_r == hist_r);
            // Idle bus level is high, so reset to one; level moves only on two equal samples
            always_ff @(posedge clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    meta_r <= 1'b1;
                    sync_r <= 1'b1;
                    hist_r <= 1'b1;
                    filt_r <= 1'b1;
                end
                else
                begin
                    meta_r <= pin_i[g];
                    sync_r <= meta_r;
                    hist_r <= sync_r;
                    filt_r <= agree ? sync_r : filt_r;
                end
            end
            assign filt_o[g] = filt_r;
        end
    endgenerate
endmodule : irr_pin_filt
`default_nettype wire

// *** src/irr_top.sv ***
// Bus slave with stop/stuck-bus recovery and reset, plus port settings
`default_nettype none
`include "irr_defs.svh"

// What this block does
// - Stop returns idle, releases data, awaits start
// - Data rising while clock high is stop
// - Slave pulls data low for bits, acks
// - Nine pulses bring slave back idle from a read; a write stays busy
// - Clocks after own transmission end transfer
// - Clock pin is input only, no stretching
// - Hard reset restores all settings to default
// - After reset, defaults set before transfers
module irr_top
    import irr_pkg::*;
(
    // System clock and reset
    input wire logic MCLK_I,
    input wire logic RST_N_I,
    // Link sampling clock
    input wire logic LCLK_I,
    // Bus pins; clock is input only
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_O,
    output logic BUSY_O,
    // Port settings
    output logic [7:0] PORT_DIR_O,
    output logic [7:0] PORT_OUT_O
);
    // Reset synchronisers, one per domain
    logic mrst_meta_r;
    logic mrst_n_r;
    logic lrst_meta_r;
    logic lrst_n_r;

    always_ff @(posedge MCLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            mrst_meta_r <= 1'b0;
            mrst_n_r <= 1'b0;
        end
        else
        begin
            mrst_meta_r <= 1'b1;
            mrst_n_r <= mrst_meta_r;
        end
    end

    // Link logic held idle until the release reaches its domain
    always_ff @(posedge LCLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            lrst_meta_r <= 1'b0;
            lrst_n_r <= 1'b0;
        end
        else
        begin
            lrst_meta_r <= 1'b1;
            lrst_n_r <= lrst_meta_r;
        end
    end

    // Filtered pin levels; the clock pin is only ever sampled, never driven
    logic [1:0] filt;
    irr_pin_filt u_filt
    (
        .clk_i(LCLK_I),
        .rst_n_i(lrst_n_r),
        .pin_i({SCL_I, SDA_I}),
        .filt_o(filt)
    );
    wire scl = filt[1];
    wire sda = filt[0];

    // Link state
    irr_state_t st_r;
    irr_state_t st_nxt;
    logic scl_prev_r;
    logic sda_prev_r;
    logic [3:0] cnt_r;
    logic [7:0] sh_r;
    logic [7:0] tx_r;
    logic rw_r;
    logic first_r;
    logic ptr_r;
    logic oe_r;
    logic sda_o_r;
    logic busy_r;
    logic [7:0] dir_sh_r;
    logic [7:0] out_sh_r;
    logic wr_tgl_r;
    logic wr_idx_r;
    logic [7:0] wr_data_r;

    // Bus events from filtered levels
    wire scl_rise = scl & ~scl_prev_r;
    wire scl_fall = ~scl & scl_prev_r;
    wire start_ev = scl & scl_prev_r & sda_prev_r & ~sda;
    wire stop_ev = scl & scl_prev_r & ~sda_prev_r & sda;
    wire last_bit = (cnt_r == `IRR_BITS_PER_BYTE);
    wire addr_hit = (sh_r[7:1] == `IRR_DEV_ADDR);
    wire [7:0] rd_byte = (ptr_r == `IRR_REG_DIR) ? dir_sh_r : out_sh_r;
    wire master_ack = ~sh_r[0];

    // Next state; stop and start take priority over any bit activity
    always_comb
    begin
        st_nxt = st_r;
        if (stop_ev)
            st_nxt = IRR_IDLE;
        else if (start_ev)
            st_nxt = IRR_ADDR;
        else if (scl_fall)
        begin
            case (st_r)
                IRR_ADDR: if (last_bit) st_nxt = addr_hit ? IRR_AACK : IRR_IDLE;
                IRR_AACK: st_nxt = rw_r ? IRR_RDATA : IRR_WDATA;
                IRR_WDATA: if (last_bit) st_nxt = IRR_WACK;
                IRR_WACK: st_nxt = IRR_WDATA;
                IRR_RDATA: if (last_bit) st_nxt = IRR_RACK;
                // No ack from master (recovery clocks leave data high) ends the transfer
                IRR_RACK: st_nxt = master_ack ? IRR_RDATA : IRR_IDLE;
                default: st_nxt = IRR_IDLE;
            endcase
        end
    end

    // Sequencing: bit count, shift in on rise, drive changes on fall
    always_ff @(posedge LCLK_I or negedge lrst_n_r)
    begin
        if (!lrst_n_r)
        begin
            st_r <= IRR_IDLE;
            scl_prev_r <= 1'b1;
            sda_prev_r <= 1'b1;
            cnt_r <= `IRR_CNT_ZERO;
            sh_r <= `IRR_BYTE_ZERO;
            tx_r <= `IRR_BYTE_ZERO;
            rw_r <= 1'b0;
            first_r <= 1'b1;
            ptr_r <= `IRR_REG_DIR;
            oe_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            scl_prev_r <= scl;
            sda_prev_r <= sda;
            if (stop_ev || start_ev)
            begin
                cnt_r <= `IRR_CNT_ZERO;
                oe_r <= 1'b0;
                first_r <= 1'b1;
            end
            else if (scl_rise && st_r != IRR_IDLE)
            begin
                sh_r <= {sh_r[6:0], sda};
                cnt_r <= cnt_r + `IRR_CNT_ONE;
            end
            else if (scl_fall)
            begin
                case (st_r)
                    IRR_ADDR:
                    begin
                        oe_r <= last_bit & addr_hit;
                        rw_r <= sh_r[0];
                    end
                    IRR_AACK, IRR_WACK:
                    begin
                        cnt_r <= `IRR_CNT_ZERO;
                        tx_r <= rd_byte;
                        oe_r <= rw_r & (st_r == IRR_AACK) & ~rd_byte[7];
                    end
                    IRR_WDATA:
                    begin
                        oe_r <= last_bit;
                        if (last_bit)
                        begin
                            first_r <= 1'b0;
                            if (first_r)
                                ptr_r <= sh_r[0];
                        end
                    end
                    IRR_RDATA:
                    begin
                        tx_r <= {tx_r[6:0], 1'b0};
                        oe_r <= ~last_bit & ~tx_r[6];
                    end
                    IRR_RACK:
                    begin
                        cnt_r <= `IRR_CNT_ZERO;
                        tx_r <= rd_byte;
                        oe_r <= master_ack & ~rd_byte[7];
                    end
                    default: oe_r <= 1'b0;
                endcase
            end
        end
    end

    // Link-side copy of the settings and the hand-off word to the system side
    wire wr_commit = scl_fall & (st_r == IRR_WDATA) & last_bit & ~first_r;
    always_ff @(posedge LCLK_I or negedge lrst_n_r)
    begin
        if (!lrst_n_r)
        begin
            dir_sh_r <= `IRR_DIR_RST;
            out_sh_r <= `IRR_OUT_RST;
            wr_tgl_r <= 1'b0;
            wr_idx_r <= `IRR_REG_DIR;
            wr_data_r <= `IRR_BYTE_ZERO;
        end
        else if (wr_commit && !stop_ev && !start_ev)
        begin
            if (ptr_r == `IRR_REG_DIR)
                dir_sh_r <= sh_r;
            else
                out_sh_r <= sh_r;
            wr_idx_r <= ptr_r;
            wr_data_r <= sh_r;
            wr_tgl_r <= ~wr_tgl_r;
        end
    end

    // Pin drivers; data is open drain so the driven value is always low
    always_ff @(posedge LCLK_I or negedge lrst_n_r)
    begin
        if (!lrst_n_r)
        begin
            sda_o_r <= 1'b0;
            busy_r <= 1'b0;
        end
        else
        begin
            sda_o_r <= 1'b0;
            busy_r <= (st_nxt != IRR_IDLE);
        end
    end

    // System side: toggle crossing; the word is stable many link cycles per byte
    logic tgl_meta_r;
    logic tgl_sync_r;
    logic tgl_seen_r;
    logic [7:0] dir_r;
    logic [7:0] out_r;
    wire take = tgl_sync_r ^ tgl_seen_r;
    always_ff @(posedge MCLK_I or negedge mrst_n_r)
    begin
        if (!mrst_n_r)
        begin
            tgl_meta_r <= 1'b0;
            tgl_sync_r <= 1'b0;
            tgl_seen_r <= 1'b0;
            dir_r <= `IRR_DIR_RST;
            out_r <= `IRR_OUT_RST;
        end
        else
        begin
            tgl_meta_r <= wr_tgl_r;
            tgl_sync_r <= tgl_meta_r;
            tgl_seen_r <= tgl_sync_r;
            if (take && wr_idx_r == `IRR_REG_DIR)
                dir_r <= wr_data_r;
            if (take && wr_idx_r == `IRR_REG_OUT)
                out_r <= wr_data_r;
        end
    end

    assign SDA_O = sda_o_r;
    assign SDA_OE_O = oe_r;
    assign BUSY_O = busy_r;
    assign PORT_DIR_O = dir_r;
    assign PORT_OUT_O = out_r;
endmodule : irr_top
`default_nettype wire

// *** tb/irr_top_checker.sv ***
// Pin checks for the bus slave
`default_nettype none
module irr_top_checker
(
    // Clocks and reset
    input wire logic MCLK_I,
    input wire logic RST_N_I,
    input wire logic LCLK_I,
    // Bus and port pins
    input wire logic SCL_I,
    input wire logic SDA_I,
    input wire logic SDA_O,
    input wire logic SDA_OE_O,
    input wire logic BUSY_O,
    input wire logic [7:0] PORT_DIR_O,
    input wire logic [7:0] PORT_OUT_O
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] rise_r;
    // Clock rises under our own drive; a stuck slave would pass nine
    always_ff @(posedge LCLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            rise_r <= 4'h0;
        else if (!SDA_OE_O)
            rise_r <= 4'h0;
        else if ($rose(SCL_I))
            rise_r <= rise_r + 4'h1;
    end
    AST_OPEN_DRAIN: assert property (@(posedge LCLK_I) disable iff (!RST_N_I)
        SDA_O == 1'h0) else $error("data high");
    AST_STOP_FREE: assert property (@(posedge LCLK_I) disable iff (!RST_N_I)
        SCL_I && $rose(SDA_I) |-> ##10 !SDA_OE_O) else $error("held after stop");
    AST_STOP_IDLE: assert property (@(posedge LCLK_I) disable iff (!RST_N_I)
        SCL_I && $rose(SDA_I) |-> ##10 !BUSY_O) else $error("busy after stop");
    AST_NO_STRETCH: assert property (@(posedge LCLK_I) disable iff (!RST_N_I)
        $rose(SDA_OE_O) |-> !SCL_I) else $error("drive in clock high");
    AST_NINE_PULSES: assert property (@(posedge LCLK_I) disable iff (!RST_N_I)
        rise_r <= 4'h9) else $error("held past nine");
    AST_RESET_IDLE: assert property (@(posedge LCLK_I) disable iff (!RST_N_I)
        $rose(RST_N_I) |-> !SDA_OE_O && !BUSY_O) else $error("busy at reset");
    AST_PORT_DEFAULT: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        $rose(RST_N_I) |-> (PORT_DIR_O == 8'hFF && PORT_OUT_O == 8'hFF) [*2])
        else $error("port default");
    AST_PORT_IN_XFER: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        !$stable({PORT_DIR_O, PORT_OUT_O}) |-> BUSY_O) else $error("port change idle");
endmodule : irr_top_checker
bind irr_top irr_top_checker u_irr_top_checker (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I),
    .LCLK_I(LCLK_I), .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
    .BUSY_O(BUSY_O), .PORT_DIR_O(PORT_DIR_O), .PORT_OUT_O(PORT_OUT_O));
`default_nettype wire

// *** tb/irr_master_model.sv ***
// Behavioural bus master on the clock and data lines
`default_nettype none
module irr_master_model
(
    // Timing
    input wire logic clk_i,
    // Bus
    input wire logic sda_i,
    output logic scl_o = 1'h1,
    output logic sda_low_o = 1'h0
);
    timeunit 1ns;
    timeprecision 100ps;
    int q = 12; // Quarter bit; raise it to slow the master
    // Lines move only after falling edges
    task automatic wt();
        repeat (q) @(negedge clk_i);
    endtask : wt
    // Start, also a repeated start
    task automatic start();
        sda_low_o = 1'h0;
        wt();
        scl_o = 1'h1;
        wt();
        sda_low_o = 1'h1;
        wt();
        scl_o = 1'h0;
    endtask : start
    // Only the master makes a stop
    task automatic stop();
        wt();
        sda_low_o = 1'h1;
        wt();
        scl_o = 1'h1;
        wt();
        sda_low_o = 1'h0;
        wt();
    endtask : stop
    // One pulse; data set while the clock is low
    task automatic bit_x(input logic b, output logic r);
        wt();
        sda_low_o = !b;
        wt();
        scl_o = 1'h1;
        wt();
        r = sda_i;
        wt();
        scl_o = 1'h0;
    endtask : bit_x
    // Eight bits MSB first and the ack slot
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--)
            bit_x(tx[i], rx[i]);
    endtask : xfer
    // One system-clock low pulse on data, too short to pass the slave's filter
    task automatic glitch();
        sda_low_o = 1'h1;
        @(negedge clk_i);
        sda_low_o = 1'h0;
    endtask : glitch
    // Blind pulses with data released free a stuck bus
    task automatic recover();
        logic r;
        repeat (9) bit_x(1'h1, r);
    endtask : recover
endmodule : irr_master_model
`default_nettype wire

// *** tb/irr_top_test.sv ***
// Bench for the bus slave recovery and reset
`default_nettype none
module irr_top_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'h0;
    logic lclk = 1'h0;
    logic rst_n = 1'h0;
    logic scl, m_low, sda_o, sda_oe, busy, r;
    logic [7:0] dir, outv;
    logic [8:0] rx;
    int num_errors = 0;
    int total_checks = 0;
    // Pulled-up data wire
    wire sda = !(m_low || (sda_oe && !sda_o));
    // Clocks
    always #5 mclk = !mclk;
    always #7.5 lclk = !lclk;
    irr_top u_irr_top (.MCLK_I(mclk), .RST_N_I(rst_n), .LCLK_I(lclk), .SCL_I(scl),
        .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe), .BUSY_O(busy),
        .PORT_DIR_O(dir), .PORT_OUT_O(outv));
    irr_master_model m (.clk_i(mclk), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));
    task automatic chk(input logic g, input logic e);
        total_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("unexpected value at %0t: %b", $time, g);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out
    // Bounded wait for idle; a hang ends the run
    task automatic idle();
        int n;
        n = 0;
        while (busy !== 1'h0 && n < 200)
        begin
            @(negedge mclk);
            n++;
        end
        chk(busy, 1'h0);
        chk(sda_oe, 1'h0);
        if (n == 200 && busy !== 1'h0)
            close_out();
    endtask : idle
    // Short data pulses while idle; spacing moves each one to a new link-clock phase
    task automatic s_glitch();
        for (int i = 0; i < 3; i++)
        begin
            m.glitch();
            repeat (3) @(negedge mclk);
            chk(busy, 1'h0);
        end
        repeat (10) @(negedge mclk);
        chk(busy, 1'h0);
    endtask : s_glitch
    // Write one register with acks checked
    task automatic wr(input logic p, input logic [7:0] v);
        m.start();
        m.xfer({8'h44, 1'h1}, rx);
        chk(rx[0], 1'h0);
        m.xfer({7'h00, p, 1'h1}, rx);
        chk(rx[0], 1'h0);
        m.xfer({v, 1'h1}, rx);
        chk(rx[0], 1'h0);
        m.stop();
        idle();
    endtask : wr
    // Back to back writes, slow read, refused address
    task automatic s_xfer();
        chk(dir === 8'hFF && outv === 8'hFF, 1'h1);
        wr(1'h1, 8'hC3);
        wr(1'h0, 8'h5A);
        chk(dir === 8'h5A && outv === 8'hC3, 1'h1);
        m.q = 20;
        m.start();
        m.xfer({8'h45, 1'h1}, rx);
        m.xfer({8'hFF, 1'h0}, rx);
        chk(rx[8:1] === 8'h5A, 1'h1);
        m.xfer({8'hFF, 1'h1}, rx);
        chk(rx[8:1] === 8'h5A, 1'h1);
        m.stop();
        idle();
        m.q = 12;
        m.start();
        m.xfer({8'h46, 1'h1}, rx);
        chk(rx[0], 1'h1);
        m.stop();
        idle();
    endtask : s_xfer
    // Read aborted with data held low, freed by nine pulses
    task automatic s_recover();
        wr(1'h1, 8'h00);
        m.start();
        m.xfer({8'h45, 1'h1}, rx);
        repeat (3) m.bit_x(1'h1, r);
        chk(sda, 1'h0);
        m.recover();
        idle();
        chk(sda, 1'h1);
        m.stop();
        wr(1'h1, 8'hA5);
        chk(outv === 8'hA5, 1'h1);
    endtask : s_recover
    // Hard reset while the slave pulls data low
    task automatic s_hard();
        m.start();
        m.xfer({8'h45, 1'h1}, rx);
        m.bit_x(1'h1, r);
        repeat (12) @(negedge mclk);
        chk(sda_oe, 1'h1);
        rst_n = 1'h0;
        repeat (3) @(negedge mclk);
        chk(sda_oe || busy, 1'h0);
        chk(dir === 8'hFF && outv === 8'hFF, 1'h1);
        repeat (7) @(negedge mclk);
        rst_n = 1'h1;
        repeat (20) @(negedge mclk);
        m.stop();
        wr(1'h0, 8'h81);
        chk(dir === 8'h81 && outv === 8'hFF, 1'h1);
    endtask : s_hard
    // Main sequence
    initial
    begin
        repeat (10) @(negedge mclk);
        rst_n = 1'h1;
        repeat (20) @(negedge mclk);
        s_glitch();
        s_xfer();
        s_recover();
        s_hard();
        close_out();
    end
endmodule : irr_top_test
`default_nettype wire
